// file: hw/tsc_defines.svh
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

`define TSC_RES_W 12
`define TSC_AXI_AW 8
`define TSC_OFF_SAMPLE 8'h00
`define TSC_OFF_STATUS 8'h04
`define TSC_OFF_COUNT 8'h08
`define TSC_SAMPLE_RST 12'h000
`define TSC_CTRL_RST 8'h00
`define TSC_CW_MODE 3
`define TSC_CW_SER 2
`define TSC_CW_PD_HI 1
`define TSC_CW_PD_LO 0
`define TSC_PD_AUTO_IRQ 2'h0
`define TSC_PD_FULL 2'h3
`define TSC_BITS_12 4'hC
`define TSC_BITS_8 4'h8
`define TSC_ACQ_CNT 3'h4
`define TSC_WORD_LAST 3'h7
`define TSC_ST_POWER 8
`define TSC_ST_SWITCH 9
`define TSC_ST_BUSY 10
`define TSC_ST_IRQEN 11
`define TSC_ST_ACQ 12
`define TSC_ST_CONV 13
`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2
`define TSC_CLK_MHZ 100
`define TSC_DO_MAX_NS 200

`endif

// file: hw/tsc_pkg.sv
`include "tsc_defines.svh"
package tsc_pkg;
  typedef enum logic [1:0] {TSC_PH_IDLE, TSC_PH_ACQ, TSC_PH_CONV} tsc_phase_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic sclk_prev;
  } tsc_sync_t;

  typedef struct packed {
    logic [`TSC_RES_W-1:0] data;
  } tsc_shift_t;

  typedef struct packed {
    tsc_phase_t phase;
    logic rx_active;
    logic rx_done;
    logic [2:0] rx_cnt;
    logic [7:0] rx_shift;
    logic [7:0] ctrl_word;
    logic [3:0] out_cnt;
    logic dout;
    logic busy;
    logic [15:0] conv_count;
    logic [`TSC_RES_W-1:0] sample;
    logic aw_held;
    logic w_held;
    logic [`TSC_AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tsc_state_t;
endpackage

// file: hw/tsc_ifs.sv
`timescale 1ns/1ps
`include "tsc_defines.svh"
interface tsc_link_if;
  logic cs_act;
  logic din;
  logic rise;
  logic fall;
  modport src(output cs_act, din, rise, fall);
  modport dst(input cs_act, din, rise, fall);
endinterface

interface tsc_shift_if;
  logic load;
  logic shift;
  logic [`TSC_RES_W-1:0] sample;
  logic msb;
  modport ctrl(output load, shift, sample, input msb);
  modport dp(input load, shift, sample, output msb);
endinterface

// file: hw/tsc_pin_sync.sv
`timescale 1ns/1ps
module tsc_pin_sync
  import tsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic serial_shift_clock,
  input wire logic din,
  tsc_link_if.src lk
);
  tsc_sync_t r_reg;
  tsc_sync_t r_next;

  // bit 2 select, bit 1 shift clock, bit 0 data; s1 is read only by s2
  always_comb begin
    r_next = r_reg;
    r_next.s1 = {cs_n, serial_shift_clock, din};
    r_next.s2 = r_reg.s1;
    r_next.sclk_prev = r_reg.s2[1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '{s1: 3'h4, s2: 3'h4, sclk_prev: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  // edges only count while select is low
  assign lk.cs_act = !r_reg.s2[2];
  assign lk.din = r_reg.s2[0];
  assign lk.rise = !r_reg.s2[2] && r_reg.s2[1] && !r_reg.sclk_prev;
  assign lk.fall = !r_reg.s2[2] && !r_reg.s2[1] && r_reg.sclk_prev;
endmodule

// file: hw/tsc_result_shift.sv
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_result_shift
  import tsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  tsc_shift_if.dp sh
);
  tsc_shift_t r_reg;
  tsc_shift_t r_next;

  // straight binary: the code leaves unchanged, msb first
  always_comb begin
    r_next = r_reg;
    if (sh.load) begin
      r_next.data = sh.sample;
    end else if (sh.shift) begin
      r_next.data = {r_reg.data[`TSC_RES_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '{data: `TSC_SAMPLE_RST};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sh.msb = r_reg.data[`TSC_RES_W-1];
endmodule

// file: hw/tsc_conv_ctrl.sv
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_conv_ctrl
  import tsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic serial_shift_clock,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic busy,
  output logic busy_oe,
  output logic power_up,
  output logic drive_switch_on,
  output logic touch_irq_enable,
  input wire logic [`TSC_AXI_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [`TSC_AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready
);
  localparam int DO_MAX_CYC = `TSC_DO_MAX_NS * `TSC_CLK_MHZ / 1000;

  tsc_state_t r_reg;
  tsc_state_t r_next;
  tsc_link_if lk();
  tsc_shift_if sh();
  logic [1:0] pd_sel;
  logic ser_mode;
  logic [31:0] status_w;

  // every check below runs on the bus clock and sleeps through reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic addr_hit(input logic [`TSC_AXI_AW-1:0] a,
                                    input logic [`TSC_AXI_AW-1:0] off);
    return a[`TSC_AXI_AW-1:2] == off[`TSC_AXI_AW-1:2];
  endfunction

  function automatic logic addr_mapped(input logic [`TSC_AXI_AW-1:0] a);
    return addr_hit(a, `TSC_OFF_SAMPLE) || addr_hit(a, `TSC_OFF_STATUS) ||
           addr_hit(a, `TSC_OFF_COUNT);
  endfunction

  tsc_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .cs_n(cs_n),
    .serial_shift_clock(serial_shift_clock),
    .din(din),
    .lk(lk.src)
  );

  tsc_result_shift u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .sh(sh.dp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // settings of the conversion in force

  assign pd_sel = r_reg.ctrl_word[`TSC_CW_PD_HI:`TSC_CW_PD_LO];
  assign ser_mode = r_reg.ctrl_word[`TSC_CW_SER];

  // reserved code 10 behaves as auto power-down with the irq off
  assign power_up = (pd_sel == `TSC_PD_FULL) || (r_reg.phase != TSC_PH_IDLE);
  assign drive_switch_on = (r_reg.phase == TSC_PH_ACQ) ||
                           ((r_reg.phase == TSC_PH_CONV) && !ser_mode);
  assign touch_irq_enable = !power_up && (pd_sel == `TSC_PD_AUTO_IRQ);

  assign dout = r_reg.dout;
  assign busy = r_reg.busy;
  assign dout_oe = lk.cs_act;
  assign busy_oe = lk.cs_act;

  assign sh.sample = r_reg.sample;
  assign sh.load = lk.fall && r_reg.rx_done;
  assign sh.shift = lk.fall && !r_reg.rx_done && (r_reg.phase == TSC_PH_CONV) &&
                    (r_reg.out_cnt != 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  assign status_w = {18'h0, r_reg.phase == TSC_PH_CONV, r_reg.phase == TSC_PH_ACQ,
                     touch_irq_enable, r_reg.busy, drive_switch_on, power_up,
                     r_reg.ctrl_word};

  assign s_axil_awready = !r_reg.aw_held && !r_reg.bvalid;
  assign s_axil_wready = !r_reg.w_held && !r_reg.bvalid;
  assign s_axil_bvalid = r_reg.bvalid;
  assign s_axil_bresp = r_reg.bresp;
  assign s_axil_arready = !r_reg.rvalid;
  assign s_axil_rvalid = r_reg.rvalid;
  assign s_axil_rdata = r_reg.rdata;
  assign s_axil_rresp = r_reg.rresp;

  always_comb begin
    r_next = r_reg;
    if (s_axil_awvalid && s_axil_awready) begin
      r_next.aw_held = 1'b1;
      r_next.aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      r_next.w_held = 1'b1;
      r_next.w_data = s_axil_wdata;
      r_next.w_strb = s_axil_wstrb;
    end
    if (r_reg.aw_held && r_reg.w_held) begin
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = addr_mapped(r_reg.aw_addr) ? `TSC_RESP_OKAY : `TSC_RESP_SLVERR;
      // status and count ignore writes
      if (addr_hit(r_reg.aw_addr, `TSC_OFF_SAMPLE)) begin
        if (r_reg.w_strb[0]) begin
          r_next.sample[7:0] = r_reg.w_data[7:0];
        end
        if (r_reg.w_strb[1]) begin
          r_next.sample[`TSC_RES_W-1:8] = r_reg.w_data[`TSC_RES_W-1:8];
        end
      end
    end
    if (r_reg.bvalid && s_axil_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (s_axil_arvalid && !r_reg.rvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = addr_mapped(s_axil_araddr) ? `TSC_RESP_OKAY : `TSC_RESP_SLVERR;
      if (addr_hit(s_axil_araddr, `TSC_OFF_SAMPLE)) begin
        r_next.rdata = {20'h0, r_reg.sample};
      end else if (addr_hit(s_axil_araddr, `TSC_OFF_STATUS)) begin
        r_next.rdata = status_w;
      end else if (addr_hit(s_axil_araddr, `TSC_OFF_COUNT)) begin
        r_next.rdata = {16'h0, r_reg.conv_count};
      end else begin
        r_next.rdata = 32'h0;
      end
    end else if (r_reg.rvalid && s_axil_rready) begin
      r_next.rvalid = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // serial link
    if (!lk.cs_act) begin
      // deselect abandons the frame; the latched settings stay
      r_next.rx_active = 1'b0;
      r_next.rx_done = 1'b0;
      r_next.phase = TSC_PH_IDLE;
      r_next.out_cnt = 4'h0;
      r_next.dout = 1'b0;
      r_next.busy = 1'b0;
    end else if (lk.rise) begin
      if (!r_reg.rx_active && !r_reg.rx_done) begin
        if (lk.din) begin
          r_next.rx_active = 1'b1;
          r_next.rx_cnt = 3'h1;
          r_next.rx_shift = 8'h01;
        end
      end else if (r_reg.rx_active) begin
        r_next.rx_shift = {r_reg.rx_shift[6:0], lk.din};
        r_next.rx_cnt = r_reg.rx_cnt + 3'h1;
        // channel known: sample from here unless a result is still leaving
        if ((r_reg.rx_cnt == `TSC_ACQ_CNT) && (r_reg.phase != TSC_PH_CONV)) begin
          r_next.phase = TSC_PH_ACQ;
        end
        if (r_reg.rx_cnt == `TSC_WORD_LAST) begin
          r_next.rx_active = 1'b0;
          r_next.rx_done = 1'b1;
        end
      end
    end else if (lk.fall) begin
      if (r_reg.rx_done) begin
        r_next.rx_done = 1'b0;
        r_next.ctrl_word = r_reg.rx_shift;
        r_next.phase = TSC_PH_CONV;
        r_next.busy = 1'b1;
        r_next.dout = 1'b0;
        r_next.out_cnt = r_reg.rx_shift[`TSC_CW_MODE] ? `TSC_BITS_8 : `TSC_BITS_12;
      end else if ((r_reg.phase == TSC_PH_CONV) && (r_reg.out_cnt != 4'h0)) begin
        r_next.busy = 1'b0;
        r_next.dout = sh.msb;
        r_next.out_cnt = r_reg.out_cnt - 4'h1;
        if (r_reg.out_cnt == 4'h1) begin
          r_next.phase = TSC_PH_IDLE;
          r_next.conv_count = r_reg.conv_count + 16'h1;
        end
      end else begin
        r_next.busy = 1'b0;
        r_next.dout = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.phase <= TSC_PH_IDLE;
      r_reg.ctrl_word <= `TSC_CTRL_RST;
      r_reg.sample <= `TSC_SAMPLE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  busy_on_start_a: assert property (lk.fall && r_reg.rx_done |-> ##[1:DO_MAX_CYC] busy)
    else $error("busy did not rise at conversion start");
  dout_float_a: assert property (cs_n |-> ##2 !dout_oe)
    else $error("serial output driven while deselected");
  busy_float_a: assert property (cs_n |-> ##2 !busy_oe ##1 !busy)
    else $error("busy driven while deselected");
  ignore_clk_a: assert property (!lk.cs_act |=> r_reg.phase == TSC_PH_IDLE && !r_reg.rx_active)
    else $error("activity while deselected");
  start_bit_a: assert property (lk.rise && !r_reg.rx_active && !r_reg.rx_done && !lk.din
                                |=> !r_reg.rx_active)
    else $error("word started without start bit");
  full_power_a: assert property (pd_sel == `TSC_PD_FULL |-> power_up)
    else $error("powered down in full power mode");
  auto_pd_a: assert property (lk.fall && r_reg.phase == TSC_PH_CONV && r_reg.out_cnt == 4'h1 &&
                              pd_sel != `TSC_PD_FULL && !r_reg.rx_done |=> !power_up)
    else $error("still powered after conversion");
  switch_ser_a: assert property (r_reg.phase == TSC_PH_CONV && ser_mode
                                 |-> !drive_switch_on)
    else $error("switches closed during single-ended conversion");
  switch_dfr_a: assert property ($rose(r_reg.phase == TSC_PH_CONV) && !ser_mode
                                 |-> drive_switch_on && $past(drive_switch_on))
    else $error("switches opened during differential conversion");
  bits_8_a: assert property (lk.fall && r_reg.rx_done && r_reg.rx_shift[`TSC_CW_MODE]
                             |=> r_reg.out_cnt == `TSC_BITS_8)
    else $error("eight-bit length wrong");
  dout_bit_a: assert property (sh.shift |=> dout == $past(sh.msb))
    else $error("result bit not presented");
  dout_low_a: assert property (lk.fall && !r_reg.rx_done && r_reg.phase != TSC_PH_CONV
                               |=> !dout)
    else $error("output not low after result");
  din_capture_a: assert property (lk.rise && r_reg.rx_active
                                  |=> r_reg.rx_shift[0] == $past(lk.din))
    else $error("input bit not captured");

  // pin enables trail the select pin by the two synchroniser stages
  dout_enable_a: assert property (!cs_n |-> ##2 dout_oe)
    else $error("serial output not enabled while selected");
  busy_enable_a: assert property (!cs_n |-> ##2 busy_oe)
    else $error("busy not enabled while selected");
  deselect_clear_a: assert property (!lk.cs_act |=> !dout && !busy)
    else $error("outputs not cleared on deselect");
  settings_kept_a: assert property (!lk.cs_act |=> $stable(r_reg.ctrl_word))
    else $error("settings changed while deselected");

  // conversion sequence
  word_end_a: assert property (lk.rise && r_reg.rx_active && r_reg.rx_cnt == `TSC_WORD_LAST
                               |=> r_reg.rx_done)
    else $error("control word not closed after eight bits");
  acq_start_a: assert property (lk.rise && r_reg.rx_active && r_reg.rx_cnt == `TSC_ACQ_CNT &&
                                r_reg.phase == TSC_PH_IDLE
                                |=> r_reg.phase == TSC_PH_ACQ)
    else $error("acquisition did not start");
  conv_start_a: assert property (lk.fall && r_reg.rx_done |=> !dout && r_reg.phase == TSC_PH_CONV)
    else $error("conversion did not start");
  out_len_12_a: assert property (lk.fall && r_reg.rx_done && !r_reg.rx_shift[`TSC_CW_MODE]
                                 |=> r_reg.out_cnt == `TSC_BITS_12)
    else $error("twelve-bit length wrong");
  busy_pulse_a: assert property (busy && lk.fall |=> !busy)
    else $error("busy held past one clock");
  sample_load_a: assert property (sh.load |=> sh.msb == $past(r_reg.sample[`TSC_RES_W-1]))
    else $error("result not loaded unchanged");
  dout_hold_a: assert property (lk.cs_act && !lk.fall |=> $stable(dout))
    else $error("serial output changed off a falling edge");
  conv_count_a: assert property (lk.fall && r_reg.phase == TSC_PH_CONV &&
                                 r_reg.out_cnt == 4'h1 && !r_reg.rx_done
                                 |=> r_reg.conv_count == $past(r_reg.conv_count) + 16'h1)
    else $error("finished conversion not counted");
  acq_switch_a: assert property (r_reg.phase == TSC_PH_ACQ |-> drive_switch_on && power_up)
    else $error("switches open during acquisition");
  idle_power_a: assert property (r_reg.phase == TSC_PH_IDLE && pd_sel != `TSC_PD_FULL
                                 |-> !power_up)
    else $error("powered while idle in auto power-down");
  irq_gate_a: assert property (pd_sel != `TSC_PD_AUTO_IRQ |-> !touch_irq_enable)
    else $error("touch interrupt enabled in wrong mode");

  // bus answers stand until the master takes them
  rvalid_hold_a: assert property (s_axil_rvalid && !s_axil_rready
                                  |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read answer dropped early");
  bvalid_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
    else $error("write answer dropped early");
endmodule

// file: verification/tsc_host_model.sv
`timescale 1ns/1ps
module tsc_host_model (
  input wire logic aclk,
  output logic cs_n,
  output logic serial_shift_clock,
  output logic din,
  input wire logic dout,
  input wire logic busy,
  input wire logic power_up,
  input wire logic drive_switch_on
);
  // one bit per rising clock, rise k at index 32-k
  logic [31:0] dq, bq, pq, sq;
  initial begin
    cs_n = 1'h1;
    serial_shift_clock = 1'h0;
    din = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bits go out msb first; nclk clocks, then select is released
  task automatic frame(input logic [31:0] bits, input int nclk);
    int k;
    int wpos;
    wpos = 0;
    dq = '0;
    bq = '0;
    pq = '0;
    sq = '0;
    cs_n <= 1'h0;
    tick(12);
    for (k = 1; k <= nclk; k++) begin
      din <= bits[32-k];
      tick((wpos >= 5 && wpos < 8) ? 40 : 8);
      serial_shift_clock <= 1'h1;
      dq[32-k] = dout;
      bq[32-k] = busy;
      pq[32-k] = power_up;
      sq[32-k] = drive_switch_on;
      if (wpos == 8) wpos = 0;
      if (wpos > 0) wpos++;
      else if (bits[32-k]) wpos = 1;
      // stretched clocks keep acquisition above 1.5 us
      tick((wpos >= 5 && wpos < 8) ? 40 : 8);
      serial_shift_clock <= 1'h0;
    end
    tick(8);
    cs_n <= 1'h1;
    din <= ~din;
  endtask
  // clocks while deselected, with a start bit on the data line
  task automatic idle_clocks(input int n);
    tick(1);
    din <= 1'h1;
    repeat (2 * n) begin
      tick(8);
      serial_shift_clock <= ~serial_shift_clock;
    end
  endtask
endmodule

// file: verification/tb_tsc_conv_ctrl.sv
`timescale 1ns/1ps
module tb_tsc_conv_ctrl;
  import tsc_pkg::*;
  typedef struct packed {
    logic [11:0] smp;
    logic [1:0] lead;
    logic mode;
    logic ser;
    logic [1:0] pd;
  } tsc_row_t;
  localparam tsc_row_t ROWS [8] = '{
    '{12'h000, 2'h0, 1'h0, 1'h0, 2'h0}, '{12'hFFF, 2'h0, 1'h0, 1'h1, 2'h1},
    '{12'hA5C, 2'h3, 1'h0, 1'h0, 2'h3}, '{12'h5A3, 2'h0, 1'h1, 1'h1, 2'h2},
    '{12'h801, 2'h2, 1'h1, 1'h0, 2'h3}, '{12'h7FE, 2'h0, 1'h1, 1'h1, 2'h0},
    '{12'h001, 2'h1, 1'h0, 1'h1, 2'h1}, '{12'h3C9, 2'h0, 1'h0, 1'h0, 2'h2}};
  logic aclk, aresetn, cs_n, serial_shift_clock, din, dout, dout_oe, busy, busy_oe;
  logic power_up, drive_switch_on, touch_irq_enable;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
  logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  wire dout_w;
  wire busy_w;
  int bad_count = 0;
  int num_checks = 0;
  // an undriven line reads as the inverse, so a missing enable shows up as wrong bits
  assign dout_w = dout_oe ? dout : ~dout;
  assign busy_w = busy_oe ? busy : ~busy;
  always #5 aclk = ~aclk;
  tsc_conv_ctrl i_tsc_conv_ctrl (.aclk(aclk), .aresetn(aresetn), .cs_n(cs_n),
    .serial_shift_clock(serial_shift_clock), .din(din), .dout(dout), .dout_oe(dout_oe),
    .busy(busy), .busy_oe(busy_oe), .power_up(power_up), .drive_switch_on(drive_switch_on),
    .touch_irq_enable(touch_irq_enable), .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready));
  tsc_host_model i_tsc_host_model (.aclk(aclk), .cs_n(cs_n),
    .serial_shift_clock(serial_shift_clock), .din(din), .dout(dout_w), .busy(busy_w),
    .power_up(power_up), .drive_switch_on(drive_switch_on));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    s_axil_bready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'h0;
      if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'h0;
      if (s_axil_bvalid) break;
    end
    r = s_axil_bresp;
    s_axil_bready <= 1'h0;
    if (n == 100) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'h0;
      if (s_axil_rvalid) break;
    end
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'h0;
    if (n == 100) begin
      bad_count++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i, k, lw, nb;
    tsc_row_t rw;
    logic [7:0] cw;
    logic [31:0] ex, d, cnt;
    logic [1:0] r;
    aclk = 1'h0;
    aresetn = 1'h0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    s_axil_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({touch_irq_enable, power_up, dout_oe, busy_oe}, 4'h8);
    axr(8'h04, d, r);
    chk(d, 32'h800);
    axr(8'h08, d, r);
    chk(d, 32'h0);
    cnt = 0;
    for (i = 0; i < 8; i++) begin
      rw = ROWS[i];
      lw = rw.lead;
      nb = rw.mode ? 8 : 12;
      cw = {1'h1, 3'h5, rw.mode, rw.ser, rw.pd};
      axw(8'h00, {20'h0, rw.smp}, r);
      chk(r, 2'h0);
      i_tsc_host_model.frame({cw, 24'h0} >> lw, 24);
      for (k = 1; k <= 32; k++) begin
        ex[32-k] = (k >= lw + 10 && k < lw + 10 + nb) ? rw.smp[lw+21-k] : 1'h0;
      end
      chk(i_tsc_host_model.dq, ex);
      chk((i_tsc_host_model.bq >> (22 - lw)) & 32'h7, 32'h2);
      chk(i_tsc_host_model.sq[25-lw], 1'h1);
      chk(i_tsc_host_model.sq[20-lw], !rw.ser);
      chk(i_tsc_host_model.pq[20-lw], 1'h1);
      repeat (8) @(posedge aclk);
      chk(dout_oe | busy_oe, 1'h0);
      chk(power_up, rw.pd == 2'h3);
      chk(touch_irq_enable, rw.pd == 2'h0);
      cnt++;
      axr(8'h08, d, r);
      chk(d, cnt);
      axr(8'h04, d, r);
      chk(d[7:0], cw);
    end
    // two eight-bit conversions, second word overlapping the first result
    cw = 8'hAF;
    axw(8'h00, 32'h9C4, r);
    i_tsc_host_model.frame({cw, 4'h0, cw, 12'h0}, 32);
    chk(i_tsc_host_model.dq, {9'h0, 8'h9C, 4'h0, 8'h9C, 3'h0});
    cnt = cnt + 2;
    axr(8'h08, d, r);
    chk(d, cnt);
    // abort in mid-conversion, then clocks while deselected
    cw = 8'h84;
    i_tsc_host_model.frame({cw, 24'h0}, 12);
    i_tsc_host_model.idle_clocks(12);
    repeat (8) @(posedge aclk);
    chk({dout_oe, busy_oe, power_up}, 3'h0);
    axr(8'h08, d, r);
    chk(d, cnt);
    axw(8'h04, 32'h0, r);
    chk(r, 2'h0);
    axr(8'h04, d, r);
    chk(d[7:0], cw);
    axr(8'h0C, d, r);
    chk(d, 32'h0);
    chk(r, 2'h2);
    axw(8'h0C, 32'h1, r);
    chk(r, 2'h2);
    axr(8'h00, d, r);
    chk(d, 32'h9C4);
    // reset in mid-run: settings, count and sample return to their reset values
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({touch_irq_enable, power_up, dout_oe, busy_oe}, 4'h8);
    axr(8'h04, d, r);
    chk(d, 32'h800);
    axr(8'h08, d, r);
    chk(d, 32'h0);
    axr(8'h00, d, r);
    chk(d, 32'h0);
    complete_run();
  end
endmodule
